//--- flts_sram.sv
// flts_sram: flow-through synchronous sram with late write and burst counter
`timescale 1ns/10ps

// How it works
// - 262,144 words of 18 bits, 18-bit address
// - read data valid the cycle after command
// - write data taken one edge after command
// - reads and writes interleave with no idle
// - low lane enables write their own bytes
// - write controls and address registered together
// - writes work with output enable always active
// - any deselecting chip select floats the data
// - advance continues bursts and deselects without address
// - advance ignores address, selects, read/write select
// - advance steps counter in chosen burst order
// - clock hold high freezes every operation
// - load low starts read or write
// - order high interleaved, low linear mod four
// - lane enables sampled on every write beat
// - inactive output enable stops data drive
module flts_sram #(
  parameter int AW = flts_pkg::ADDR_W,
  parameter int DW = flts_pkg::DATA_W,
  parameter int LW = flts_pkg::LANE_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // command
  input wire logic [AW-1:0] addr_i,
  input wire logic burst_step_or_load_i,
  input wire logic read_not_write_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_i,
  input wire logic chip_select_c_n_i,
  input wire logic [DW/LW-1:0] byte_lane_write_n_i,
  input wire logic clock_hold_n_i,
  // asynchronous and static pins
  input wire logic output_enable_n_i,
  input wire logic burst_order_select_i,
  input wire logic sleep_request_i,
  // data pins
  input wire logic [DW-1:0] dq_i,
  output logic [DW-1:0] dq_o,
  output logic dq_oe_o
);

  localparam int NL = DW / LW;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if ((DW % LW) != 0 || AW < 3) begin : g_bad_geom
    $error("flts_sram: data width must be whole lanes, address at least 3 bits");
  end

  // ------------------------------------------------------------
  // pin synchroniser for output enable, order select and sleep
  // ------------------------------------------------------------
  localparam logic [flts_pkg::SYNC_PINS-1:0] SYNC_RST =
    {flts_pkg::SLEEP_RST, flts_pkg::ORDER_RST, flts_pkg::OE_N_RST};

  logic [flts_pkg::SYNC_PINS-1:0] sync_a;
  logic [flts_pkg::SYNC_PINS-1:0] sync_b;
  logic [flts_pkg::SYNC_PINS-1:0] sync_c;
  logic [flts_pkg::SYNC_PINS-1:0] pin_lvl;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
      sync_c <= SYNC_RST;
    end else begin
      sync_a <= {sleep_request_i, burst_order_select_i, output_enable_n_i};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // a pin level counts once the last two stages agree
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_lvl <= SYNC_RST;
    end else begin
      for (int i = 0; i < flts_pkg::SYNC_PINS; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          pin_lvl[i] <= sync_c[i];
        end
      end
    end
  end

  logic oe_n_lvl;
  logic interleave;
  logic sleep_lvl;

  assign oe_n_lvl = pin_lvl[flts_pkg::PIN_OE_N];
  assign interleave = pin_lvl[flts_pkg::PIN_ORDER];
  assign sleep_lvl = pin_lvl[flts_pkg::PIN_SLEEP];

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic en;
  logic load;
  logic selected;
  flts_pkg::flts_op_e load_op;

  assign en = !clock_hold_n_i && !sleep_lvl;
  assign load = !burst_step_or_load_i;
  assign selected = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;

  always_comb begin
    if (!selected) begin
      load_op = flts_pkg::FLTS_DESEL;
    end else if (read_not_write_i) begin
      load_op = flts_pkg::FLTS_READ;
    end else begin
      load_op = flts_pkg::FLTS_WRITE;
    end
  end

  // ------------------------------------------------------------
  // burst address counter
  // ------------------------------------------------------------
  logic [AW-1:0] cur_addr;
  logic [AW-1:0] next_addr;
  flts_pkg::flts_op_e cur_op;
  flts_pkg::flts_op_e next_op;

  // while advancing the counter ignores address, selects and read/write
  flts_burst #(
    .AW(AW)
  ) u_burst (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .en_i(en),
    .load_i(load),
    .load_addr_i(addr_i),
    .load_op_i(load_op),
    .interleave_i(interleave),
    .cur_addr_o(cur_addr),
    .cur_op_o(cur_op),
    .next_addr_o(next_addr),
    .next_op_o(next_op)
  );

  // ------------------------------------------------------------
  // late-write pipeline
  // ------------------------------------------------------------
  logic wr_pend;
  logic [AW-1:0] wr_addr;
  logic [NL-1:0] wr_lanes_n;

  // address and lane enables of a write beat wait one edge for their data
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'h0;
      wr_addr <= '0;
      wr_lanes_n <= '1;
    end else if (en) begin
      wr_pend <= (next_op == flts_pkg::FLTS_WRITE);
      wr_addr <= next_addr;
      wr_lanes_n <= byte_lane_write_n_i;
    end
  end

  // ------------------------------------------------------------
  // array and read path
  // ------------------------------------------------------------
  logic mem_we;
  logic mem_re;
  logic [NL-1:0] mem_wbe;

  assign mem_we = en && wr_pend;
  assign mem_wbe = ~wr_lanes_n;
  assign mem_re = en && (next_op == flts_pkg::FLTS_READ);

  // write data forwards into a read of the same word, so no dead cycle
  flts_mem #(
    .AW(AW),
    .DW(DW),
    .LW(LW)
  ) u_mem (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .we_i(mem_we),
    .waddr_i(wr_addr),
    .wdata_i(dq_i),
    .wbe_i(mem_wbe),
    .re_i(mem_re),
    .raddr_i(next_addr),
    .rdata_o(dq_o)
  );

  // ------------------------------------------------------------
  // output drive
  // ------------------------------------------------------------
  logic rd_active;
  logic next_rd_active;

  assign next_rd_active = en ? (next_op == flts_pkg::FLTS_READ) : rd_active;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_active <= 1'h0;
    end else begin
      rd_active <= next_rd_active;
    end
  end

  // output enable only gates the drive, write path never looks at it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dq_oe_o <= 1'h0;
    end else begin
      dq_oe_o <= next_rd_active && !oe_n_lvl && !sleep_lvl;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_read_drive;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && load && selected && read_not_write_i && !oe_n_lvl) |=> dq_oe_o;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read did not drive data the next cycle");

  property p_deselect_float;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && load && !selected) |=> !dq_oe_o [*1] ##0 !rd_active;
  endproperty
  a_deselect_float: assert property (p_deselect_float)
    else $error("deselect left data driven");

  property p_oe_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
      oe_n_lvl |=> !dq_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data driven with output enable inactive");

  property p_write_capture;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && load && selected && !read_not_write_i)
        |=> wr_pend && (wr_addr == $past(addr_i)) && (wr_lanes_n == $past(byte_lane_write_n_i));
  endproperty
  a_write_capture: assert property (p_write_capture)
    else $error("write command not registered with its address");

  property p_write_late;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && next_op == flts_pkg::FLTS_WRITE) ##1 en |-> mem_we && (mem_wbe == ~wr_lanes_n);
  endproperty
  a_write_late: assert property (p_write_late)
    else $error("write data not taken one edge after command");

  property p_hold_write;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wr_pend && !en) |-> !mem_we ##1 (wr_pend && $stable(wr_addr));
  endproperty
  a_hold_write: assert property (p_hold_write)
    else $error("stalled write data capture not delayed");

  property p_hold_freeze;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !en |=> $stable(cur_addr) && $stable(rd_active) && $stable(dq_o) && $stable(wr_pend);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("state changed during clock hold");

  property p_advance_keeps_op;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && !load) |=> (cur_op == $past(cur_op));
  endproperty
  a_advance_keeps_op: assert property (p_advance_keeps_op)
    else $error("advance changed the burst operation");

  property p_advance_upper;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && !load) |=> (cur_addr[AW-1:2] == $past(cur_addr[AW-1:2]));
  endproperty
  a_advance_upper: assert property (p_advance_upper)
    else $error("burst changed upper address bits");

  property p_linear_step;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && !load && !interleave) ##1 !interleave
        |-> (cur_addr[1:0] == 2'($past(cur_addr[1:0]) + 2'h1));
  endproperty
  a_linear_step: assert property (p_linear_step)
    else $error("linear burst did not step by one");

  property p_load_read;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (en && load && selected && read_not_write_i) |=> rd_active && cur_addr == $past(addr_i);
  endproperty
  a_load_read: assert property (p_load_read)
    else $error("load did not start a read at the new address");

  c_write_then_read: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    (en && next_op == flts_pkg::FLTS_WRITE) ##1 (en && next_op == flts_pkg::FLTS_READ));
  c_read_burst: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    (en && load && selected && read_not_write_i) ##1 (en && !load) [*3]);
  c_hold_pending: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    (wr_pend && !en) ##1 (wr_pend && en));

endmodule : flts_sram

//--- flts_pkg.sv
// flts_pkg: constants, types and helpers for the flow-through late-write sram
package flts_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 18;
  localparam int WORDS = 262144;
  localparam int LANE_W = 9;
  localparam int LANES = 2;

  // ------------------------------------------------------------
  // clock and pin synchroniser
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYNC_PINS = 3;
  localparam int PIN_OE_N = 0;
  localparam int PIN_ORDER = 1;
  localparam int PIN_SLEEP = 2;

  // ------------------------------------------------------------
  // values after reset and the beat step
  // ------------------------------------------------------------
  localparam logic OE_N_RST = 1'h1;
  localparam logic ORDER_RST = 1'h1;
  localparam logic SLEEP_RST = 1'h0;
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;

  // ------------------------------------------------------------
  // operation of the current burst
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FLTS_DESEL,
    FLTS_READ,
    FLTS_WRITE
  } flts_op_e;

  // low two address bits of a beat: interleaved xor, else linear mod four
  function automatic logic [1:0] flts_burst_low(input logic [1:0] start,
                                                input logic [1:0] beat,
                                                input logic interleave);
    if (interleave) begin
      return start ^ beat;
    end
    return 2'(start + beat);
  endfunction : flts_burst_low

endpackage : flts_pkg

//--- flts_mem.sv
// flts_mem: word array with byte lanes and registered, write-forwarded read data
`timescale 1ns/10ps
module flts_mem #(
  parameter int AW = 18,
  parameter int DW = 18,
  parameter int LW = 9
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [DW/LW-1:0] wbe_i,
  // read port
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  localparam int NL = DW / LW;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      for (int l = 0; l < NL; l++) begin
        if (wbe_i[l]) begin
          mem[waddr_i][l*LW +: LW] <= wdata_i[l*LW +: LW];
        end
      end
    end
  end

  // a read of the word being written sees the new lanes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      for (int l = 0; l < NL; l++) begin
        if (we_i && wbe_i[l] && (waddr_i == raddr_i)) begin
          rdata_o[l*LW +: LW] <= wdata_i[l*LW +: LW];
        end else begin
          rdata_o[l*LW +: LW] <= mem[raddr_i][l*LW +: LW];
        end
      end
    end
  end

endmodule : flts_mem

//--- flts_burst.sv
// flts_burst: loaded address, burst beat counter and operation of the burst
`timescale 1ns/10ps
module flts_burst #(
  parameter int AW = 18
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // control
  input wire logic en_i,
  input wire logic load_i,
  input wire logic [AW-1:0] load_addr_i,
  input wire flts_pkg::flts_op_e load_op_i,
  input wire logic interleave_i,
  // current and next state
  output logic [AW-1:0] cur_addr_o,
  output flts_pkg::flts_op_e cur_op_o,
  output logic [AW-1:0] next_addr_o,
  output flts_pkg::flts_op_e next_op_o
);

  logic [AW-1:0] base;
  logic [1:0] beat;
  flts_pkg::flts_op_e op;
  logic [AW-1:0] next_base;
  logic [1:0] next_beat;

  always_comb begin
    next_base = load_i ? load_addr_i : base;
    next_beat = load_i ? flts_pkg::BEAT_RST : 2'(beat + flts_pkg::BEAT_STEP);
    next_op_o = load_i ? load_op_i : op;
    next_addr_o = {next_base[AW-1:2],
                   flts_pkg::flts_burst_low(next_base[1:0], next_beat, interleave_i)};
    cur_addr_o = {base[AW-1:2], flts_pkg::flts_burst_low(base[1:0], beat, interleave_i)};
    cur_op_o = op;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base <= '0;
      beat <= flts_pkg::BEAT_RST;
      op <= flts_pkg::FLTS_DESEL;
    end else if (en_i) begin
      base <= next_base;
      beat <= next_beat;
      op <= next_op_o;
    end
  end

endmodule : flts_burst

//--- flts_master.sv
// flts_master: bus master model issuing commands and late write data
`timescale 1ns/10ps
module flts_master (
  // clock and read return
  input wire logic mclk_i,
  input wire logic [17:0] dq_o_i,
  input wire logic dq_oe_i,
  // command
  output logic [17:0] addr_o,
  output logic step_o,
  output logic rnw_o,
  output logic [2:0] sel_o,
  output logic [1:0] lane_n_o,
  output logic hold_o,
  // static pins and write data
  output logic oe_n_o,
  output logic order_o,
  output logic sleep_o,
  output logic [17:0] wdata_o
);
  logic oe_n_req = 1'h0;
  logic order_req = 1'h1;
  logic sleep_req = 1'h0;
  logic [17:0] q;
  logic oe;

  initial begin
    addr_o = 18'h0;
    step_o = 1'h0;
    rnw_o = 1'h1;
    sel_o = 3'h5;
    lane_n_o = 2'h3;
    hold_o = 1'h0;
    oe_n_o = 1'h0;
    order_o = 1'h1;
    sleep_o = 1'h0;
    wdata_o = 18'h0;
  end

  // one cycle: keep the result of the last edge, drive off the edge, wait for it
  task automatic beat(input logic st, input logic rnw, input logic [2:0] sel,
                      input logic [17:0] a, input logic [1:0] ln, input logic hd,
                      input logic wv, input logic [17:0] wd);
    @(negedge mclk_i);
    q = dq_o_i;
    oe = dq_oe_i;
    step_o = st;
    rnw_o = rnw;
    sel_o = sel;
    addr_o = a;
    lane_n_o = ln;
    hold_o = hd;
    oe_n_o = oe_n_req;
    order_o = order_req;
    sleep_o = sleep_req;
    // data belongs to the previous command; an idle bus keeps moving
    wdata_o = wv ? wd : ~wdata_o;
    @(posedge mclk_i);
  endtask : beat
endmodule : flts_master

//--- flts_sram_tb_top.sv
// flts_sram_tb_top: self-checking bench for the flow-through late-write sram
`timescale 1ns/10ps
module flts_sram_tb_top;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DSL = 3'h5;
  logic mclk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [17:0] addr;
  logic [17:0] wdata;
  logic [17:0] dq_o;
  logic [2:0] sel;
  logic [1:0] lane_n;
  logic step;
  logic rnw;
  logic hold;
  logic oe_n;
  logic order;
  logic sleep;
  logic dq_oe;
  logic [17:0] img [4];
  int num_errors = 0;
  int samples_checked = 0;

  always #20 mclk_i = ~mclk_i;

  flts_sram DUT (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr),
    .burst_step_or_load_i(step),
    .read_not_write_i(rnw),
    .chip_select_a_n_i(sel[2]),
    .chip_select_b_i(sel[1]),
    .chip_select_c_n_i(sel[0]),
    .byte_lane_write_n_i(lane_n),
    .clock_hold_n_i(hold),
    .output_enable_n_i(oe_n),
    .burst_order_select_i(order),
    .sleep_request_i(sleep),
    .dq_i(wdata),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe)
  );

  flts_master m (
    .mclk_i(mclk_i),
    .dq_o_i(dq_o),
    .dq_oe_i(dq_oe),
    .addr_o(addr),
    .step_o(step),
    .rnw_o(rnw),
    .sel_o(sel),
    .lane_n_o(lane_n),
    .hold_o(hold),
    .oe_n_o(oe_n),
    .order_o(order),
    .sleep_o(sleep),
    .wdata_o(wdata)
  );

  // ------------------------------------------------------------
  // checks and bus helpers
  // ------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [17:0] e, input logic [17:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_flag(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag

  task automatic ld(input logic r, input logic [17:0] a, input logic [1:0] ln,
                    input logic wv, input logic [17:0] wd);
    m.beat(1'h0, r, SEL, a, ln, 1'h0, wv, wd);
  endtask : ld

  // address, selects and direction carry junk: an advance must ignore them
  task automatic burst_step(input logic [1:0] ln, input logic hd, input logic wv, input logic [17:0] wd);
    m.beat(1'h1, 1'h0, DSL, 18'h2aaaa, ln, hd, wv, wd);
  endtask : burst_step

  task automatic idle(input logic wv, input logic [17:0] wd);
    m.beat(1'h0, 1'h1, DSL, 18'h0, 2'h3, 1'h0, wv, wd);
  endtask : idle

  task automatic rd_chk(input logic [17:0] e);
    chk_word("dq_o", e, m.q);
    chk_flag("dq_oe_o", 1'h1, m.oe);
  endtask : rd_chk

  function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] k, input logic il);
    return il ? (s ^ k) : 2'(s + k);
  endfunction : nxt

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_rw();
    ld(1'h0, 18'h3ffff, 2'h0, 1'h0, 18'h0);
    ld(1'h1, 18'h3ffff, 2'h0, 1'h1, 18'h2a5c3);
    ld(1'h0, 18'h00000, 2'h0, 1'h0, 18'h0);
    rd_chk(18'h2a5c3);
    ld(1'h1, 18'h00000, 2'h0, 1'h1, 18'h15a3c);
    idle(1'h0, 18'h0);
    rd_chk(18'h15a3c);
    idle(1'h0, 18'h0);
    chk_flag("dq_oe_o", 1'h0, m.oe);
  endtask : t_rw

  task automatic t_lanes();
    ld(1'h0, 18'h00010, 2'h0, 1'h0, 18'h0);
    ld(1'h0, 18'h00010, 2'h1, 1'h1, 18'h3ffff);
    ld(1'h0, 18'h00010, 2'h2, 1'h1, 18'h0);
    ld(1'h0, 18'h00010, 2'h3, 1'h1, 18'h3fe55);
    ld(1'h1, 18'h00010, 2'h0, 1'h1, 18'h0);
    idle(1'h0, 18'h0);
    rd_chk(18'h00055);
  endtask : t_lanes

  task automatic t_bwrite();
    logic [17:0] d;
    ld(1'h0, 18'h00122, 2'h0, 1'h0, 18'h0);
    for (int k = 0; k < 4; k++) begin
      d = 18'h1c000 + 18'(k);
      img[2'h2 ^ 2'(k)] = d;
      if (k < 3) burst_step(2'h0, 1'h0, 1'h1, d);
      else idle(1'h1, d);
    end
  endtask : t_bwrite

  task automatic t_bread(input logic il, input logic [1:0] s);
    m.order_req = il;
    repeat (4) idle(1'h0, 18'h0);
    ld(1'h1, {16'h0048, s}, 2'h0, 1'h0, 18'h0);
    for (int k = 1; k < 6; k++) begin
      burst_step(2'h0, 1'h0, 1'h0, 18'h0);
      rd_chk(img[nxt(s, 2'(k - 1), il)]);
    end
  endtask : t_bread

  task automatic t_hold();
    ld(1'h0, 18'h00200, 2'h0, 1'h0, 18'h0);
    burst_step(2'h0, 1'h0, 1'h1, 18'h00a01);
    burst_step(2'h0, 1'h1, 1'h1, 18'h3ffff);
    burst_step(2'h0, 1'h0, 1'h1, 18'h00a02);
    idle(1'h1, 18'h00a03);
    ld(1'h1, 18'h00200, 2'h0, 1'h0, 18'h0);
    burst_step(2'h0, 1'h1, 1'h0, 18'h0);
    rd_chk(18'h00a01);
    burst_step(2'h0, 1'h0, 1'h0, 18'h0);
    rd_chk(18'h00a01);
    burst_step(2'h0, 1'h0, 1'h0, 18'h0);
    rd_chk(18'h00a02);
    idle(1'h0, 18'h0);
    rd_chk(18'h00a03);
    ld(1'h0, 18'h00200, 2'h0, 1'h0, 18'h0);
    burst_step(2'h1, 1'h0, 1'h1, 18'h3fe00);
    idle(1'h1, 18'h00000);
    ld(1'h1, 18'h00201, 2'h0, 1'h0, 18'h0);
    idle(1'h0, 18'h0);
    rd_chk(18'h00002);
  endtask : t_hold

  task automatic t_desel();
    for (int i = 0; i < 3; i++) begin
      ld(1'h1, 18'h3ffff, 2'h0, 1'h0, 18'h0);
      m.beat(1'h0, 1'h1, SEL ^ 3'(1 << i), 18'h3ffff, 2'h0, 1'h0, 1'h0, 18'h0);
      rd_chk(18'h2a5c3);
      burst_step(2'h0, 1'h0, 1'h0, 18'h0);
      chk_flag("dq_oe_o", 1'h0, m.oe);
      burst_step(2'h0, 1'h0, 1'h0, 18'h0);
      chk_flag("dq_oe_o", 1'h0, m.oe);
    end
  endtask : t_desel

  task automatic t_oe();
    m.oe_n_req = 1'h1;
    repeat (4) idle(1'h0, 18'h0);
    ld(1'h1, 18'h3ffff, 2'h0, 1'h0, 18'h0);
    idle(1'h0, 18'h0);
    chk_flag("dq_oe_o", 1'h0, m.oe);
    m.oe_n_req = 1'h0;
    repeat (4) idle(1'h0, 18'h0);
  endtask : t_oe

  // sleep must ignore a read and a write, and float the data
  task automatic t_sleep();
    m.sleep_req = 1'h1;
    repeat (4) idle(1'h0, 18'h0);
    ld(1'h1, 18'h3ffff, 2'h0, 1'h0, 18'h0);
    ld(1'h0, 18'h3ffff, 2'h0, 1'h0, 18'h0);
    chk_flag("dq_oe_o", 1'h0, m.oe);
    idle(1'h1, 18'h0);
    m.sleep_req = 1'h0;
    repeat (4) idle(1'h0, 18'h0);
    ld(1'h1, 18'h3ffff, 2'h0, 1'h0, 18'h0);
    idle(1'h0, 18'h0);
    rd_chk(18'h2a5c3);
  endtask : t_sleep

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (10) @(negedge mclk_i);
    reset_n_i = 1'h1;
    repeat (4) idle(1'h0, 18'h0);
    t_rw();
    t_lanes();
    t_bwrite();
    t_bread(1'h1, 2'h1);
    t_bread(1'h0, 2'h3);
    t_hold();
    t_desel();
    t_oe();
    t_sleep();
    end_of_test();
  end

  // about 100 cycles are needed; cut a hang at 3000
  initial begin
    #(3000 * 40);
    num_errors++;
    end_of_test();
  end
endmodule : flts_sram_tb_top
